/* phpc_map.vh */
// Register map, field positions, reset values and timing of the port pin block
`ifndef PHPC_MAP_VH
`define PHPC_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define PHPC_OFS_DATA 10'h0260
`define PHPC_OFS_READBACK 10'h0261
`define PHPC_OFS_DIRECTION 10'h0262
`define PHPC_OFS_DRIVE 10'h0263
`define PHPC_OFS_PULL 10'h0264

// ****************************************
// Reset values
// ****************************************
`define PHPC_RST_DATA 8'h00
`define PHPC_RST_DIRECTION 8'h00
`define PHPC_RST_DRIVE 8'h00
`define PHPC_RST_PULL 8'hff

// ****************************************
// Field positions
// ****************************************
`define PHPC_LCD_LO 4
`define PHPC_PIN_SS_SDA 3
`define PHPC_PIN_SCK_CLK 2
`define PHPC_PIN_MOSI 1
`define PHPC_PIN_MISO_SCL 0

// ****************************************
// Timing
// ****************************************
`define PHPC_SYNC_STAGES 2

`endif

/* phpc_sync.v */
// Two-flop synchroniser for the eight pin input levels
`timescale 1ns/1ps
module phpc_sync
#(
    parameter WIDTH = 8
)
(
    // Clock, reset, enable
    input wire mclk_i,
    input wire rst_i,
    input wire ce_i,
    // Data
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);

reg [WIDTH-1:0] stage1;

// First stage feeds only the second stage
always @(posedge mclk_i)
begin
    if (rst_i)
    begin
        stage1 <= {WIDTH{1'b0}};
        sync_o <= {WIDTH{1'b0}};
    end
    else if (ce_i)
    begin
        stage1 <= async_i;
        sync_o <= stage1;
    end
end

endmodule

/* phpc_port.v */
// Port pin control: registers, direction priority, drive and pull control
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`include "phpc_map.vh"
module phpc_port
#(
    parameter WIDTH = 8
)
(
    // Clock, reset, enable
    input wire mclk_i,
    input wire rst_i,
    input wire ce_i,
    // Avalon-MM slave
    input wire [9:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [7:0] avs_writedata_i,
    output reg [7:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    // Pin levels and drive
    input wire [7:0] pin_level_i,
    output reg [7:0] pin_out_o,
    output reg [7:0] pin_oe_o,
    output reg [7:0] pin_ie_o,
    output reg [7:0] reduced_drive_o,
    output reg [7:0] pull_active_o,
    // Segment driver
    input wire [7:4] lcd_seg_en_i,
    // I2C alternate function
    input wire i2c_en_i,
    input wire i2c_routed_i,
    input wire [1:0] i2c_oe_i,
    input wire [1:0] i2c_out_i,
    // SPI alternate function
    input wire spi_en_i,
    input wire spi_routed_i,
    input wire [3:0] spi_oe_i,
    input wire [3:0] spi_out_i,
    // Bus clock output
    input wire bus_clock_output_en_i,
    input wire bus_clock_output_i
);

// ****************************************
// Registers
// ****************************************
reg [7:0] port_output_data;
reg [7:0] pin_direction_bits;
reg [7:0] reduced_drive_bits;
reg [7:0] pull_enable_bits;
wire [7:0] pin_level_readback;
reg [7:0] next_oe;
reg [7:0] next_out;
reg [7:0] next_ie;
reg [7:0] next_rdata;
reg pending;

// Read mux data for the data register
function [7:0] phpc_data_view;
    input [7:0] stored;
    input [7:0] dir;
    input [7:0] level;
    begin
        phpc_data_view = (stored & dir) | (level & ~dir);
    end
endfunction

// ****************************************
// Input synchroniser
// ****************************************
// Readback is synchronised, so reads trail the pin by two clocks
phpc_sync #(
    .WIDTH(WIDTH)
) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i(pin_level_i),
    .sync_o(pin_level_readback)
);

// ****************************************
// Direction priority per pin
// ****************************************
always @*
begin
    // Default is plain I/O driven by the direction bits
    next_oe = pin_direction_bits;
    next_out = port_output_data;
    next_ie = 8'hff;
    // Pin 3: I2C data beats SPI select beats plain I/O
    if (i2c_en_i && i2c_routed_i)
    begin
        next_oe[3] = i2c_oe_i[1];
        next_out[3] = i2c_out_i[1];
    end
    else if (spi_en_i && spi_routed_i)
    begin
        next_oe[3] = spi_oe_i[3];
        next_out[3] = spi_out_i[3];
    end
    // Pin 2: SPI clock beats bus clock output
    if (spi_en_i && spi_routed_i)
    begin
        next_oe[2] = spi_oe_i[2];
        next_out[2] = spi_out_i[2];
    end
    else if (bus_clock_output_en_i)
    begin
        next_oe[2] = 1'b1;
        next_out[2] = bus_clock_output_i;
    end
    // Pin 1: SPI only
    if (spi_en_i && spi_routed_i)
    begin
        next_oe[1] = spi_oe_i[1];
        next_out[1] = spi_out_i[1];
    end
    // Pin 0: I2C clock beats SPI input
    if (i2c_en_i && i2c_routed_i)
    begin
        next_oe[0] = i2c_oe_i[0];
        next_out[0] = i2c_out_i[0];
    end
    else if (spi_en_i && spi_routed_i)
    begin
        next_oe[0] = spi_oe_i[0];
        next_out[0] = spi_out_i[0];
    end
    // Segment drive wins on every upper pin; low pins keep their drive
    // Only pins 7-4 carry segments in this block
    next_oe[7:4] = next_oe[7:4] & ~lcd_seg_en_i;
    next_ie[7:4] = ~lcd_seg_en_i;
end

// ****************************************
// Pin drive outputs
// ****************************************
// Registered so every top output comes from a flop
always @(posedge mclk_i)
begin
    if (rst_i)
    begin
        pin_out_o <= 8'h00;
        pin_oe_o <= 8'h00;
        pin_ie_o <= 8'hff;
        reduced_drive_o <= 8'h00;
        pull_active_o <= `PHPC_RST_PULL;
    end
    else if (ce_i)
    begin
        pin_out_o <= next_out;
        pin_oe_o <= next_oe;
        pin_ie_o <= next_ie;
        reduced_drive_o <= reduced_drive_bits & next_oe;
        pull_active_o <= pull_enable_bits & ~next_oe & next_ie;
    end
end

// ****************************************
// Read data select
// ****************************************
always @*
begin
    case (avs_address_i)
        `PHPC_OFS_DATA:
            next_rdata = phpc_data_view(port_output_data,
                pin_direction_bits, pin_level_readback);
        `PHPC_OFS_READBACK:
            next_rdata = pin_level_readback;
        `PHPC_OFS_DIRECTION:
            next_rdata = pin_direction_bits;
        `PHPC_OFS_DRIVE:
            next_rdata = reduced_drive_bits;
        `PHPC_OFS_PULL:
            next_rdata = pull_enable_bits;
        default:
            next_rdata = 8'h00; // Unmapped reads return zero
    endcase
end

// ****************************************
// Avalon slave: one wait cycle per access
// ****************************************
// A fixed single wait state keeps read data registered and simple
always @(posedge mclk_i)
begin
    if (rst_i)
    begin
        pending <= 1'b0;
        avs_waitrequest_o <= 1'b1;
        avs_readdata_o <= 8'h00;
        port_output_data <= `PHPC_RST_DATA;
        pin_direction_bits <= `PHPC_RST_DIRECTION;
        reduced_drive_bits <= `PHPC_RST_DRIVE;
        pull_enable_bits <= `PHPC_RST_PULL;
    end
    else if (ce_i)
    begin
        if (pending)
        begin
            pending <= 1'b0;
            avs_waitrequest_o <= 1'b1;
        end
        else if (avs_read_i)
        begin
            pending <= 1'b1;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= next_rdata;
        end
        else if (avs_write_i)
        begin
            pending <= 1'b1;
            avs_waitrequest_o <= 1'b0;
            case (avs_address_i)
                `PHPC_OFS_DATA:
                    port_output_data <= avs_writedata_i;
                `PHPC_OFS_DIRECTION:
                    pin_direction_bits <= avs_writedata_i;
                `PHPC_OFS_DRIVE:
                    reduced_drive_bits <= avs_writedata_i;
                `PHPC_OFS_PULL:
                    pull_enable_bits <= avs_writedata_i;
                default:
                    pending <= 1'b1; // Readback and unmapped: ignored
            endcase
        end
    end
end

endmodule

/* phpc_port_asserts.sv */
// Checker for the port pin block
`timescale 1ns/1ps
module phpc_port_asserts
(
    // Clock and bus
    input wire mclk_i,
    input wire rst_i,
    input wire ce_i,
    input wire avs_read_i,
    input wire avs_waitrequest_o,
    // Pin side
    input wire [7:0] pin_oe_o,
    input wire [7:0] pin_ie_o,
    input wire [7:0] reduced_drive_o,
    input wire [7:0] pull_active_o,
    input wire [7:4] lcd_seg_en_i,
    input wire i2c_en_i,
    input wire i2c_routed_i,
    input wire [1:0] i2c_oe_i,
    input wire spi_en_i,
    input wire spi_routed_i,
    input wire [3:0] spi_oe_i,
    input wire bus_clock_output_en_i
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    wire i2c_on = i2c_en_i && i2c_routed_i;
    wire spi_on = spi_en_i && spi_routed_i;
    // Direction and input-enable outputs are only judged after a clean running edge
    reg v;
    always @(posedge mclk_i)
        v <= ce_i && !rst_i;
    a_read_answer: assert property ($rose(avs_read_i) && avs_waitrequest_o
        && ce_i |=> !avs_waitrequest_o) else $error("read not answered");
    a_answer_pulse: assert property (!avs_waitrequest_o |=>
        avs_waitrequest_o) else $error("answer longer than one cycle");
    a_seg_off: assert property (v |-> ((pin_oe_o[7:4] | pin_ie_o[7:4]) &
        $past(lcd_seg_en_i)) == 4'h0) else $error("segment pin active");
    a_pin3_i2c: assert property (v && $past(i2c_on) |->
        pin_oe_o[3] == $past(i2c_oe_i[1])) else $error("pin3 direction");
    a_pin0_i2c: assert property (v && $past(i2c_on) |->
        pin_oe_o[0] == $past(i2c_oe_i[0])) else $error("pin0 direction");
    a_pin1_spi: assert property (v && $past(spi_on) |->
        pin_oe_o[1] == $past(spi_oe_i[1])) else $error("pin1 direction");
    a_pin2_clock: assert property (v && $past(!spi_on &&
        bus_clock_output_en_i) |-> pin_oe_o[2]) else $error("pin2 clock");
    a_drive_out: assert property ((reduced_drive_o & ~pin_oe_o) == 8'h00)
        else $error("reduced drive on input");
    a_pull_out: assert property ((pull_active_o & pin_oe_o) == 8'h00)
        else $error("pull on output");
    a_pull_reset: assert property ($past(rst_i && ce_i) |->
        pull_active_o == 8'hff) else $error("pull reset value");
endmodule
bind phpc_port phpc_port_asserts u_chk (.mclk_i, .rst_i, .ce_i, .avs_read_i,
    .avs_waitrequest_o, .pin_oe_o, .pin_ie_o, .reduced_drive_o,
    .pull_active_o, .lcd_seg_en_i, .i2c_en_i, .i2c_routed_i, .i2c_oe_i,
    .spi_en_i, .spi_routed_i, .spi_oe_i, .bus_clock_output_en_i);

/* phpc_pins.sv */
// Board model around the eight port pins
`timescale 1ns/1ps
module phpc_pins
(
    // Clock and port drive
    input wire mclk_i,
    input wire [7:0] out_i,
    input wire [7:0] oe_i,
    input wire [7:0] pull_i,
    // Board conditions
    input wire [7:0] drv_i,
    input wire [7:0] ext_i,
    input wire [7:0] short_i,
    // Levels seen at the pins
    output wire [7:0] level_o
);
    // Open pins wander so a stale level never passes
    reg [7:0] flt = 8'h55;
    always @(posedge mclk_i)
        flt <= ~flt;
    // A short to ground beats the port's own drive; pulls are taken as up
    assign level_o = ~short_i & (oe_i & out_i | ~oe_i & drv_i & ext_i
        | ~oe_i & ~drv_i & (pull_i | flt));
endmodule

/* phpc_port_tb.sv */
// Testbench for the port pin block
`timescale 1ns/1ps
module phpc_port_tb;
    reg mclk_i = 0;
    reg rst_i = 1;
    reg rd = 0;
    reg wr = 0;
    reg [9:0] adr = 0;
    reg [7:0] wd = 0;
    reg [7:4] lcd = 0;
    reg [6:0] alt_s = 0;
    reg [7:0] drv = 0;
    reg [7:0] ext = 0;
    reg [7:0] sht = 0;
    reg [7:0] got;
    reg ce = 1;
    wire [7:0] rdat, lvl, pout, poe, pie, rdrv, pull;
    wire wq;
    integer miscompares = 0;
    integer check_count = 0;
    always #4 mclk_i = ~mclk_i;
    phpc_port dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wq), .pin_level_i(lvl), .pin_out_o(pout),
        .pin_oe_o(poe), .pin_ie_o(pie), .reduced_drive_o(rdrv),
        .pull_active_o(pull), .lcd_seg_en_i(lcd), .i2c_en_i(alt_s[6]),
        .i2c_routed_i(1'b1), .i2c_oe_i(2'b10), .i2c_out_i(2'b00),
        .spi_en_i(alt_s[5]), .spi_routed_i(1'b1), .spi_oe_i(alt_s[3:0]),
        .spi_out_i(4'h0), .bus_clock_output_en_i(alt_s[4]),
        .bus_clock_output_i(mclk_i));
    phpc_pins pins (.mclk_i(mclk_i), .out_i(pout), .oe_i(poe),
        .pull_i(pull), .drv_i(drv), .ext_i(ext), .short_i(sht),
        .level_o(lvl));
    // ****
    // Tasks
    // ****
    task report_and_stop;
    begin
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task cmp(input [7:0] g, input [7:0] e);
    begin
        check_count = check_count + 1;
        if (g !== e)
        begin
            miscompares = miscompares + 1;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    end
    endtask
    // Request held until waitrequest is sampled low
    task acc(input [9:0] a, input w, input [7:0] d);
        integer n;
    begin
        @(posedge mclk_i);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        n = 0;
        @(posedge mclk_i);
        while (wq !== 1'b0 && n < 20)
        begin
            n = n + 1;
            @(posedge mclk_i);
        end
        got = rdat;
        if (n == 20)
        begin
            miscompares = miscompares + 1;
            report_and_stop;
        end
        rd <= 1'b0;
        wr <= 1'b0;
    end
    endtask
    task rdc(input [9:0] a, input [7:0] e);
    begin
        acc(a, 1'b0, 8'h00);
        cmp(got, e);
    end
    endtask
    // Synchronisers need two edges, so give three
    task settle;
    begin
        repeat (3) @(posedge mclk_i);
        #1;
    end
    endtask
    task alt(input [6:0] s, input [7:0] e);
    begin
        @(posedge mclk_i);
        alt_s <= s;
        settle;
        cmp(poe, e);
    end
    endtask
    // ****
    // Tests
    // ****
    initial
    begin
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        rdc(10'h262, 8'h00);
        rdc(10'h263, 8'h00);
        rdc(10'h264, 8'hff);
        acc(10'h100, 1'b1, 8'h5a);
        rdc(10'h100, 8'h00);
        acc(10'h262, 1'b1, 8'hff);
        acc(10'h260, 1'b1, 8'ha5);
        sht <= 8'h01;
        settle;
        cmp(poe, 8'hff);
        cmp(pout, 8'ha5);
        rdc(10'h260, 8'ha5);
        rdc(10'h261, 8'ha4);
        acc(10'h261, 1'b1, 8'h00);
        rdc(10'h262, 8'hff);
        rdc(10'h260, 8'ha5);
        sht <= 8'h00;
        drv <= 8'hff;
        ext <= 8'h3c;
        acc(10'h262, 1'b1, 8'h0f);
        settle;
        rdc(10'h260, 8'h35);
        rdc(10'h261, 8'h35);
        acc(10'h263, 1'b1, 8'hff);
        settle;
        cmp(rdrv, 8'h0f);
        cmp(pull, 8'hf0);
        acc(10'h264, 1'b1, 8'h00);
        settle;
        cmp(pull, 8'h00);
        acc(10'h262, 1'b1, 8'hff);
        lcd <= 4'hf;
        settle;
        cmp(poe, 8'h0f);
        cmp(pie & 8'hf0, 8'h00);
        lcd <= 4'h0;
        acc(10'h262, 1'b1, 8'h00);
        alt(7'b1110110, 8'h0e);
        alt(7'b1111001, 8'h08);
        alt(7'b0101001, 8'h09);
        alt(7'b0010000, 8'h04);
        alt(7'b0000000, 8'h00);
        // Clock enable low must freeze the pin drive registers
        ce <= 1'b0;
        alt(7'b0010000, 8'h00);
        ce <= 1'b1;
        settle;
        cmp(poe, 8'h04);
        report_and_stop;
    end
    // Watchdog far beyond the hundred or so cycles the tests need
    initial
    begin
        #200000;
        miscompares = miscompares + 1;
        report_and_stop;
    end
endmodule
